// File: rtl/spi_core_regs.vh
// Register map, field positions and timing constants of the serial master core
`ifndef SPI_CORE_REGS_VH
`define SPI_CORE_REGS_VH

`define ADDR_RECEIVE_DATA 3'h0
`define ADDR_TRANSMIT_DATA 3'h1
`define ADDR_CORE_STATUS 3'h2
`define ADDR_CORE_CONTROL 3'h3
`define ADDR_RESERVED_SLOT 3'h4
`define ADDR_PERIPHERAL_SELECT_MASK 3'h5

`define BIT_ANY_ERROR 8
`define BIT_RX_FULL 7
`define BIT_TX_EMPTY 6
`define BIT_SHIFTER_IDLE 5
`define BIT_TX_OVERRUN 4
`define BIT_RX_OVERRUN 3
`define BIT_FORCE_SELECT 10

`define CONTROL_RESET 16'h0000
`define SELECT_MASK_RESET 16'h0000

`define CLK_PERIOD_NS 20
`define SCLK_HALF_NS 80
`define SCLK_HALF_CYCLES ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/spi_input_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module spi_input_sync (
  input wire clk,
  input wire rst,
  input wire pin_in,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg hold_q;

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      hold_q <= level_q;
    end
  end

  // New level passes as soon as two settled stages agree; no extra register
  // so a slave bit changed on one sclk edge is seen at the next one
  always @* begin
    if (s2_q == s3_q) begin
      level_q = s3_q;
    end else begin
      level_q = hold_q;
    end
  end
endmodule // spi_input_sync

// File: rtl/spi_master_core.v
// Serial peripheral master: register file, transmit/receive shifter, select and irq
`timescale 1ns/1ns
`include "spi_core_regs.vh"
module spi_master_core #(
  parameter DATA_WIDTH = 8,
  parameter NUM_SELECTS = 1,
  parameter IS_MASTER = 1,
  parameter LSB_FIRST = 0,
  parameter CLK_POLARITY = 0,
  parameter CLK_PHASE = 0,
  parameter SCLK_HALF = `SCLK_HALF_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [2:0] address,
  input wire chip_select,
  input wire read_en,
  input wire write_en,
  input wire [15:0] write_data,
  output reg [15:0] read_data,
  output reg irq,
  output reg sclk,
  output reg mosi,
  input wire miso,
  output reg [NUM_SELECTS-1:0] ss_n
);
  localparam [5:0] LAST_TICK = 2 * DATA_WIDTH;
  localparam [15:0] DIV_LAST = SCLK_HALF - 1;
  localparam [15:0] CTRL_MASK = (IS_MASTER != 0) ? 16'h05d8 : 16'h01d8;
  localparam [15:0] DATA_MASK = (16'h0001 << DATA_WIDTH) - 16'h0001;

  wire rd = chip_select & read_en;
  wire wr = chip_select & write_en;
  wire miso_s;

  reg [DATA_WIDTH-1:0] rx_data_q;
  reg [DATA_WIDTH-1:0] tx_hold_q;
  reg [DATA_WIDTH-1:0] sh_out_q;
  reg [DATA_WIDTH-1:0] sh_in_q;
  reg [15:0] ctrl_q;
  reg [NUM_SELECTS-1:0] sel_mask_q;
  reg rx_full_q;
  reg tx_empty_q;
  reg rx_ovr_q;
  reg tx_ovr_q;
  reg busy_q;
  reg [15:0] div_q;
  reg [5:0] tick_q;

  spi_input_sync u_miso_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(miso),
    .level_q(miso_s)
  );

  // Status word built from live flags
  wire any_err = tx_ovr_q | rx_ovr_q;
  reg [15:0] status_w;
  always @* begin
    status_w = 16'h0000;
    status_w[`BIT_ANY_ERROR] = any_err;
    status_w[`BIT_RX_FULL] = rx_full_q;
    status_w[`BIT_TX_EMPTY] = tx_empty_q;
    status_w[`BIT_SHIFTER_IDLE] = ~busy_q;
    status_w[`BIT_TX_OVERRUN] = tx_ovr_q;
    status_w[`BIT_RX_OVERRUN] = rx_ovr_q;
  end

  // Bus strobes per register
  wire rd_rx = rd & (address == `ADDR_RECEIVE_DATA);
  wire wr_tx = wr & (address == `ADDR_TRANSMIT_DATA);
  wire wr_stat = wr & (address == `ADDR_CORE_STATUS);
  wire wr_ctrl = wr & (address == `ADDR_CORE_CONTROL);
  wire wr_mask = wr & (address == `ADDR_PERIPHERAL_SELECT_MASK) & (IS_MASTER != 0);

  // Shifter timing
  wire tick = busy_q & (div_q == DIV_LAST);
  wire leading = tick & (tick_q < LAST_TICK) & ~tick_q[0];
  wire trailing = tick & (tick_q < LAST_TICK) & tick_q[0];
  wire finish = tick & (tick_q == LAST_TICK);
  wire start = ~busy_q & ~tx_empty_q;
  wire sample = (CLK_PHASE == 0) ? leading : trailing;
  wire shift = (CLK_PHASE == 0) ? trailing : leading;
  wire out_bit = (LSB_FIRST != 0) ? sh_out_q[0] : sh_out_q[DATA_WIDTH-1];
  wire [DATA_WIDTH:0] out_l = {1'b0, sh_out_q};
  wire [DATA_WIDTH:0] out_m = {sh_out_q, 1'b0};
  wire [DATA_WIDTH-1:0] out_next = (LSB_FIRST != 0) ? out_l[DATA_WIDTH:1] : out_m[DATA_WIDTH-1:0];
  wire [DATA_WIDTH:0] in_l = {miso_s, sh_in_q};
  wire [DATA_WIDTH:0] in_m = {sh_in_q, miso_s};
  wire [DATA_WIDTH-1:0] in_next = (LSB_FIRST != 0) ? in_l[DATA_WIDTH:1] : in_m[DATA_WIDTH-1:0];
  wire [DATA_WIDTH-1:0] out_first = (LSB_FIRST != 0) ? tx_hold_q : tx_hold_q;
  wire first_bit = (LSB_FIRST != 0) ? out_first[0] : out_first[DATA_WIDTH-1];

  // Serial engine
  always @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      div_q <= 16'h0000;
      tick_q <= 6'h00;
      sh_out_q <= {DATA_WIDTH{1'b0}};
      sh_in_q <= {DATA_WIDTH{1'b0}};
      sclk <= (CLK_POLARITY != 0);
      mosi <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      div_q <= 16'h0000;
      tick_q <= 6'h00;
      sh_out_q <= tx_hold_q;
      if (CLK_PHASE == 0) begin
        mosi <= first_bit;
      end
    end else if (busy_q) begin
      if (tick) begin
        div_q <= 16'h0000;
        tick_q <= tick_q + 6'h01;
      end else begin
        div_q <= div_q + 16'h0001;
      end
      if (tick & ~finish) begin
        sclk <= ~sclk;
      end
      if (sample) begin
        sh_in_q <= in_next;
      end
      if (shift) begin
        if (CLK_PHASE == 0) begin
          mosi <= out_next[0] & 1'b0 | ((LSB_FIRST != 0) ? out_next[0] : out_next[DATA_WIDTH-1]);
        end else begin
          mosi <= out_bit;
        end
        sh_out_q <= out_next;
      end
      if (finish) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Holding registers and flags
  always @(posedge clk) begin
    if (rst) begin
      rx_data_q <= {DATA_WIDTH{1'b0}};
      tx_hold_q <= {DATA_WIDTH{1'b0}};
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
      rx_ovr_q <= 1'b0;
      tx_ovr_q <= 1'b0;
      ctrl_q <= `CONTROL_RESET;
      sel_mask_q <= {NUM_SELECTS{1'b0}};
    end else begin
      // Receive: finished word always lands, set beats clear
      if (finish) begin
        rx_data_q <= sh_in_q;
        rx_full_q <= 1'b1;
      end else if (rd_rx) begin
        rx_full_q <= 1'b0;
      end
      if (finish & rx_full_q & ~rd_rx) begin
        rx_ovr_q <= 1'b1;
      end else if (wr_stat) begin
        rx_ovr_q <= 1'b0;
      end
      // Transmit holding register
      if (wr_tx & ~tx_empty_q) begin
        tx_ovr_q <= 1'b1;
      end else if (wr_stat) begin
        tx_ovr_q <= 1'b0;
      end
      if (wr_tx & tx_empty_q) begin
        tx_hold_q <= write_data[DATA_WIDTH-1:0];
        tx_empty_q <= 1'b0;
      end else if (start) begin
        tx_empty_q <= 1'b1;
      end
      if (wr_ctrl) begin
        ctrl_q <= write_data & CTRL_MASK;
      end
      if (wr_mask) begin
        sel_mask_q <= write_data[NUM_SELECTS-1:0];
      end
    end
  end

  // Registered read port; reads have no side effect except on receive data
  always @(posedge clk) begin
    if (rst) begin
      read_data <= 16'h0000;
    end else if (rd) begin
      case (address)
        `ADDR_RECEIVE_DATA: read_data <= {{(16-DATA_WIDTH){1'b0}}, rx_data_q} & DATA_MASK;
        `ADDR_CORE_STATUS: read_data <= status_w;
        `ADDR_CORE_CONTROL: read_data <= ctrl_q;
        `ADDR_PERIPHERAL_SELECT_MASK: begin
          read_data <= (IS_MASTER != 0) ? {{(16-NUM_SELECTS){1'b0}}, sel_mask_q} : 16'h0000;
        end
        default: read_data <= 16'h0000;
      endcase
    end
  end

  // Interrupt and select outputs
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      ss_n <= {NUM_SELECTS{1'b1}};
    end else begin
      irq <= |(status_w & ctrl_q & 16'h01d8);
      // Select drops with the start so the slave's first bit settles in time
      if (busy_q | start | ((IS_MASTER != 0) & ctrl_q[`BIT_FORCE_SELECT])) begin
        ss_n <= ~sel_mask_q;
      end else begin
        ss_n <= {NUM_SELECTS{1'b1}};
      end
    end
  end
endmodule // spi_master_core

// File: verification/spi_master_core_properties.sv
// Port assertions for the serial master core
`timescale 1ns/1ns
module spi_master_core_properties #(parameter DATA_WIDTH = 8, parameter NUM_SELECTS = 1) (
  input wire clk,
  input wire rst,
  input wire [2:0] address,
  input wire chip_select,
  input wire read_en,
  input wire write_en,
  input wire [15:0] read_data,
  input wire irq,
  input wire sclk,
  input wire mosi,
  input wire [NUM_SELECTS-1:0] ss_n
);
  wire rd = chip_select & read_en;
  wire wr = chip_select & write_en;
  wire idle = &ss_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rsvd; rd && address == 3'h4 |=> read_data == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_err; rd && address == 3'h2 |=> read_data[8] == |read_data[4:3]; endproperty
  a_err: assert property (p_err) else $error("error flag mismatch");
  property p_undef; rd && address <= 3'h1 |=> (read_data >> DATA_WIDTH) == 16'h0000; endproperty
  a_undef: assert property (p_undef) else $error("upper data bits set");
  property p_hold; !rd |=> $stable(read_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst;
    disable iff (1'b0) rst |=> read_data == 16'h0000 && !irq && idle && !sclk && !mosi;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_irq; rd && address == 3'h3 && !wr ##1 read_data == 16'h0000 |=> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
  property p_rxclr;
    idle ##1 rd && address == 3'h0 ##2 rd && address == 3'h2 |=> !read_data[7];
  endproperty
  a_rxclr: assert property (p_rxclr) else $error("rx full kept");
  property p_stclr;
    idle ##1 wr && address == 3'h2 ##2 rd && address == 3'h2 |=> read_data[8] == 1'b0 && read_data[4:3] == 2'b00;
  endproperty
  a_stclr: assert property (p_stclr) else $error("flags not cleared");
endmodule // spi_master_core_properties

// File: verification/spi_slave_model.sv
// Serial slave model: shifts a preset byte out while capturing the host byte
`timescale 1ns/1ns
module spi_slave_model (
  input wire sclk,
  input wire mosi,
  input wire sel_n,
  input wire [7:0] out_byte,
  output reg miso,
  output reg [7:0] in_byte
);
  reg [7:0] sh;
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    sh = out_byte;
    miso = sh[7];
  end
  always @(posedge sclk) if (!sel_n) in_byte <= {in_byte[6:0], mosi};
  always @(negedge sclk) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // Released line shows the inverse of its last value
  always @(posedge sel_n) miso = ~miso;
endmodule // spi_slave_model

// File: verification/spi_master_core_tb_top.sv
// Bench for the serial master register and receive path
`timescale 1ns/1ns
module spi_master_core_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] address = 3'h0;
  reg chip_select = 1'b0;
  reg read_en = 1'b0;
  reg write_en = 1'b0;
  reg [15:0] write_data = 16'h0000;
  reg [15:0] v;
  wire [15:0] read_data;
  wire irq, sclk, mosi, miso;
  wire [0:0] ss_n;
  wire [7:0] got_byte;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  spi_master_core #(.DATA_WIDTH(8)) spi_master_core_i (.clk(clk), .rst(rst), .address(address),
    .chip_select(chip_select), .read_en(read_en), .write_en(write_en), .write_data(write_data),
    .read_data(read_data), .irq(irq), .sclk(sclk), .mosi(mosi), .miso(miso), .ss_n(ss_n));
  spi_slave_model spi_slave_model_i (.sclk(sclk), .mosi(mosi), .sel_n(ss_n[0]),
    .out_byte(8'ha5), .miso(miso), .in_byte(got_byte));
  task chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input [2:0] a, input w, input [15:0] d);
    @(posedge clk);
    address <= a;
    chip_select <= 1'b1;
    read_en <= !w;
    write_en <= w;
    write_data <= d;
    @(posedge clk);
    chip_select <= 1'b0;
    read_en <= 1'b0;
    write_en <= 1'b0;
    @(negedge clk);
    v = read_data;
  endtask
  task rd(input [2:0] a, input [15:0] exp);
    acc(a, 1'b0, 16'h0000);
    chk(v, exp);
  endtask
  task poll(input [15:0] exp);
    int n;
    v = ~exp;
    for (n = 0; n < 300 && v !== exp; n++) acc(3'h2, 1'b0, 16'h0000);
    chk(v, exp);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(3'h2, 16'h0060);
    rd(3'h3, 16'h0000);
    rd(3'h5, 16'h0000);
    acc(3'h4, 1'b1, 16'hffff);
    rd(3'h4, 16'h0000);
    acc(3'h3, 1'b1, 16'hffff);
    rd(3'h3, 16'h05d8);
    chk({15'h0000, irq}, 16'h0001);
    acc(3'h3, 1'b1, 16'h0000);
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0000);
    acc(3'h5, 1'b1, 16'hffff);
    rd(3'h5, 16'h0001);
    acc(3'h3, 1'b1, 16'h0400);
    @(negedge clk);
    chk({15'h0000, ss_n}, 16'h0000);
    acc(3'h3, 1'b1, 16'h0000);
    $display("register test done");
    acc(3'h1, 1'b1, 16'h003c);
    poll(16'h00e0);
    chk({8'h00, got_byte}, 16'h003c);
    rd(3'h0, 16'h00a5);
    rd(3'h2, 16'h0060);
    acc(3'h0, 1'b1, 16'h1234);
    rd(3'h0, 16'h00a5);
    $display("receive test done");
    acc(3'h1, 1'b1, 16'h0011);
    acc(3'h1, 1'b1, 16'h0022);
    acc(3'h1, 1'b1, 16'h0033);
    poll(16'h01f8);
    chk({8'h00, got_byte}, 16'h0022);
    acc(3'h2, 1'b1, 16'hffff);
    rd(3'h2, 16'h00e0);
    $display("overrun test done");
    test_done;
  end
endmodule // spi_master_core_tb_top
bind spi_master_core spi_master_core_properties #(.DATA_WIDTH(DATA_WIDTH),
  .NUM_SELECTS(NUM_SELECTS)) spi_master_core_properties_i (.clk(clk), .rst(rst),
  .address(address), .chip_select(chip_select), .read_en(read_en), .write_en(write_en),
  .read_data(read_data), .irq(irq), .sclk(sclk), .mosi(mosi), .ss_n(ss_n));
